/* rtl/dsd_datapath.sv */
/*
 * Arithmetic datapath of a 16-bit DSP core: shared 17x17 multiplier,
 * 40-bit ALU, two saturating accumulators, barrel shifter and the
 * data space write saturation stage.
 * Assumes operands and op codes come from core logic on the same clock,
 * one operation per cycle; no synchronisers are needed.
 */
// Functional notes
// - Shifter moves up to 16 bits right (arith or logic) or left, one cycle.
// - Shifter source is accumulator A, accumulator B or the X bus.
// - Signed amount: positive right, negative left, zero leaves operand.
// - Shifter is 40 bits; accumulator shifts give 40, general ones 16.
// - X bus word sits at bits 16-31 for right, from bit 0 for left.
// - Write saturation uses rounded word plus source and round overflow.
// - Saturating a stored word never changes the source accumulator.
// - Enabled and above 0x007FFF: stored word is 0x7FFF.
// - Enabled and below 0xFF8000: stored word is 0x8000.
// - Sign for the test comes from accumulator bit 39.
// - Saturation disabled: word is stored unmodified.
// - One 17x17 multiplier does signed, unsigned and mixed products.
// - Fractional 16x16 products are exact, even minus one squared.
// - 40-bit ALU and two independent, saturating 40-bit accumulators.
// - MAC fetches two operands, multiplies and accumulates in one cycle.
`include "dsd_consts.svh"

module dsd_datapath
(
	input  wire logic             SYS_CLK_IN,
	input  wire logic             RSTN_IN,
	input  wire dsd_pkg::dsd_op_e  OP_IN,
	input  wire logic             ACC_SEL_IN,
	input  wire dsd_pkg::dsd_src_e SHIFT_SRC_IN,
	input  wire dsd_pkg::dsd_shamt_t SHIFT_AMT_IN,
	input  wire logic             SHIFT_ARITH_IN,
	input  wire dsd_pkg::dsd_word_t XBUS_IN,
	input  wire dsd_pkg::dsd_word_t YBUS_IN,
	input  wire dsd_pkg::dsd_word_t MUL_OPA_IN,
	input  wire dsd_pkg::dsd_word_t MUL_OPB_IN,
	input  wire dsd_pkg::dsd_mul_e MUL_MODE_IN,
	input  wire logic             MUL_FRAC_IN,
	input  wire logic             ACC_SAT_EN_IN,
	input  wire logic             ROUND_EN_IN,
	input  wire logic             DATA_WRITE_SATURATION_ENABLE_IN,
	output logic [`DSD_ACC_W-1:0] ACC_A_OUT,
	output logic [`DSD_ACC_W-1:0] ACC_B_OUT,
	output logic [1:0]            ACC_OVF_OUT,
	output logic [`DSD_ACC_W-1:0] RESULT40_OUT,
	output logic [`DSD_WORD_W-1:0] RESULT16_OUT,
	output logic                  RESULT_VALID_OUT,
	output logic [`DSD_WORD_W-1:0] STORE_DATA_OUT,
	output logic                  STORE_VALID_OUT,
	output logic                  STORE_SAT_OUT,
	output logic [`DSD_WORD_W-1:0] PREFETCH_X_OUT,
	output logic [`DSD_WORD_W-1:0] PREFETCH_Y_OUT
);
	import dsd_pkg::*;

	// ======================================================================
	// Accumulator add with optional saturation; bit 40 flags overflow
	function automatic logic [`DSD_ACC_W:0] acc_add
	(
		input dsd_acc_t a,
		input dsd_acc_t b,
		input logic     sat
	);
		dsd_acc_t s;
		logic     ovf;
		s   = a + b;
		ovf = (a[`DSD_SIGN_BIT] == b[`DSD_SIGN_BIT]) &&
		      (s[`DSD_SIGN_BIT] != a[`DSD_SIGN_BIT]);
		if (ovf && sat)
			s = a[`DSD_SIGN_BIT] ? `DSD_ACC_NEG_MAX : `DSD_ACC_POS_MAX;
		return {ovf, s};
	endfunction

	// ======================================================================
	// State
	dsd_acc_t  acc [0:1];
	logic [1:0] acc_ovf;
	dsd_acc_t  result40;
	dsd_word_t result16;
	logic      result_valid;
	dsd_word_t store_data;
	logic      store_valid;
	logic      store_sat;
	dsd_word_t prefetch_x;
	dsd_word_t prefetch_y;

	// ======================================================================
	// Shared multiplier
	logic signed [`DSD_MUL_IN_W-1:0] mul_a;
	logic signed [`DSD_MUL_IN_W-1:0] mul_b;
	logic signed [`DSD_PROD_W-1:0]   product;
	dsd_acc_t                        prod40;

	always_comb
	begin
		case (MUL_MODE_IN)
			DSD_MUL_SS:
			begin
				mul_a = {MUL_OPA_IN[`DSD_WORD_W-1], MUL_OPA_IN};
				mul_b = {MUL_OPB_IN[`DSD_WORD_W-1], MUL_OPB_IN};
			end
			DSD_MUL_SU:
			begin
				mul_a = {MUL_OPA_IN[`DSD_WORD_W-1], MUL_OPA_IN};
				mul_b = {1'b0, MUL_OPB_IN};
			end
			DSD_MUL_US:
			begin
				mul_a = {1'b0, MUL_OPA_IN};
				mul_b = {MUL_OPB_IN[`DSD_WORD_W-1], MUL_OPB_IN};
			end
			default:
			begin
				mul_a = {1'b0, MUL_OPA_IN};
				mul_b = {1'b0, MUL_OPB_IN};
			end
		endcase
	end

	// 17-bit operands keep the sign apart from the magnitude bits
	assign product = mul_a * mul_b;

	// Fractional mode doubles in 40 bits, so 0x8000 squared stays positive
	always_comb
	begin
		if (MUL_FRAC_IN)
			prod40 = {{5{product[`DSD_PROD_W-1]}}, product, 1'b0};
		else
			prod40 = {{6{product[`DSD_PROD_W-1]}}, product};
	end

	// ======================================================================
	// Barrel shifter
	dsd_shift_if sh ();

	always_comb
	begin
		sh.operand   = (SHIFT_SRC_IN == DSD_SRC_ACCB) ? acc[1] : acc[0];
		sh.from_xbus = (SHIFT_SRC_IN == DSD_SRC_XBUS);
		sh.xword     = XBUS_IN;
		sh.amount    = SHIFT_AMT_IN;
		sh.arith     = SHIFT_ARITH_IN;
	end

	dsd_barrel dsd_barrel_i
	(
		.sh (sh.unit)
	);

	// ======================================================================
	// ALU: value for the destination accumulator
	dsd_acc_t next_acc;
	logic     next_acc_ovf;
	logic     acc_wr;
	logic [`DSD_ACC_W:0] sum;

	always_comb
	begin
		next_acc     = acc[ACC_SEL_IN];
		next_acc_ovf = 1'b0;
		acc_wr       = 1'b0;
		sum          = '0;
		case (OP_IN)
			DSD_OP_MAC:
			begin
				sum          = acc_add(acc[ACC_SEL_IN], prod40, ACC_SAT_EN_IN);
				next_acc     = sum[`DSD_ACC_W-1:0];
				next_acc_ovf = sum[`DSD_ACC_W];
				acc_wr       = 1'b1;
			end
			DSD_OP_ADD:
			begin
				sum          = acc_add(acc[ACC_SEL_IN], acc[~ACC_SEL_IN],
				                       ACC_SAT_EN_IN);
				next_acc     = sum[`DSD_ACC_W-1:0];
				next_acc_ovf = sum[`DSD_ACC_W];
				acc_wr       = 1'b1;
			end
			DSD_OP_LOAD:
			begin
				next_acc = {{8{XBUS_IN[`DSD_WORD_W-1]}}, XBUS_IN, `DSD_WORD_RST};
				acc_wr   = 1'b1;
			end
			DSD_OP_SHACC:
			begin
				next_acc = sh.result;
				acc_wr   = 1'b1;
			end
			default:
			begin
				acc_wr = 1'b0;
			end
		endcase
	end

	// ======================================================================
	// Accumulators; a store never writes them
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			acc[0] <= `DSD_ACC_RST;
			acc[1] <= `DSD_ACC_RST;
		end
		else if (acc_wr)
			acc[ACC_SEL_IN] <= next_acc;
	end

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			acc_ovf <= 2'h0;
		else if (acc_wr)
			acc_ovf[ACC_SEL_IN] <= next_acc_ovf;
	end

	// ======================================================================
	// MAC operand prefetch, taken in the same cycle as the accumulate
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			prefetch_x <= `DSD_WORD_RST;
			prefetch_y <= `DSD_WORD_RST;
		end
		else if (OP_IN == DSD_OP_MAC)
		begin
			prefetch_x <= XBUS_IN;
			prefetch_y <= YBUS_IN;
		end
	end

	// ======================================================================
	// Product and shift results
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			result40     <= `DSD_ACC_RST;
			result16     <= `DSD_WORD_RST;
			result_valid <= 1'b0;
		end
		else
		begin
			result_valid <= (OP_IN == DSD_OP_MUL) || (OP_IN == DSD_OP_SHGP);
			if (OP_IN == DSD_OP_MUL)
			begin
				result40 <= prod40;
				result16 <= prod40[`DSD_WORD_W-1:0];
			end
			else if (OP_IN == DSD_OP_SHGP)
			begin
				result40 <= sh.result;
				result16 <= sh.result16;
			end
		end
	end

	// ======================================================================
	// Round and data space write saturation
	dsd_acc_t  rounded;
	logic      src_ovf;
	logic      rnd_ovf;
	logic      src_neg;
	logic      wsat;
	dsd_word_t next_store;

	always_comb
	begin
		rounded = acc[ACC_SEL_IN] + (ROUND_EN_IN ? `DSD_ROUND_K : `DSD_ACC_RST);
		src_neg = acc[ACC_SEL_IN][`DSD_SIGN_BIT];
		// Word overflows when bits 39..31 are not all copies of the sign
		src_ovf = (acc[ACC_SEL_IN][`DSD_ACC_W-1:`DSD_STORE_MSB] != {9{1'b0}}) &&
		          (acc[ACC_SEL_IN][`DSD_ACC_W-1:`DSD_STORE_MSB] != {9{1'b1}});
		rnd_ovf = (rounded[`DSD_ACC_W-1:`DSD_STORE_MSB] != {9{src_neg}});
		wsat    = DATA_WRITE_SATURATION_ENABLE_IN && (src_ovf || rnd_ovf);
		if (wsat && !src_neg)
			next_store = `DSD_WSAT_POS;
		else if (wsat)
			next_store = `DSD_WSAT_NEG;
		else
			next_store = rounded[`DSD_STORE_MSB:`DSD_STORE_LSB];
	end

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			store_data  <= `DSD_WORD_RST;
			store_valid <= 1'b0;
			store_sat   <= 1'b0;
		end
		else
		begin
			store_valid <= (OP_IN == DSD_OP_STORE);
			store_sat   <= (OP_IN == DSD_OP_STORE) && wsat;
			if (OP_IN == DSD_OP_STORE)
				store_data <= next_store;
		end
	end

	// ======================================================================
	// Outputs
	assign ACC_A_OUT        = acc[0];
	assign ACC_B_OUT        = acc[1];
	assign ACC_OVF_OUT      = acc_ovf;
	assign RESULT40_OUT     = result40;
	assign RESULT16_OUT     = result16;
	assign RESULT_VALID_OUT = result_valid;
	assign STORE_DATA_OUT   = store_data;
	assign STORE_VALID_OUT  = store_valid;
	assign STORE_SAT_OUT    = store_sat;
	assign PREFETCH_X_OUT   = prefetch_x;
	assign PREFETCH_Y_OUT   = prefetch_y;
endmodule

/* rtl/dsd_consts.svh */
/*
 * Constants of the shift/saturate datapath: widths, bit positions,
 * limits and reset values.
 * Assumes it is included by bare name from the rtl/ folder.
 */
`ifndef DSD_CONSTS_SVH
`define DSD_CONSTS_SVH

// ==========================================================================
// Widths
`define DSD_ACC_W        40
`define DSD_WORD_W       16
`define DSD_MUL_IN_W     17
`define DSD_PROD_W       34
`define DSD_SHAMT_W      6

// ==========================================================================
// Shifter
`define DSD_SH_MAX       6'h10
`define DSD_SH_ZERO      6'h00
`define DSD_XR_LSB       16
`define DSD_XR_MSB       31
`define DSD_XL_LSB       0

// ==========================================================================
// Accumulators and data write saturation
`define DSD_ACC_RST      40'h00_0000_0000
`define DSD_ACC_POS_MAX  40'h7f_ffff_ffff
`define DSD_ACC_NEG_MAX  40'h80_0000_0000
`define DSD_ROUND_K      40'h00_0000_8000
`define DSD_WORD_RST     16'h0000
`define DSD_WSAT_POS     16'h7fff
`define DSD_WSAT_NEG     16'h8000
`define DSD_STORE_LSB    16
`define DSD_STORE_MSB    31
`define DSD_SIGN_BIT     39

`endif

/* rtl/dsd_pkg.sv */
/*
 * Types shared by the datapath, its shifter and the interface between them.
 * Assumes dsd_consts.svh sits beside it.
 */
`include "dsd_consts.svh"

package dsd_pkg;

	// ======================================================================
	// Types
	typedef logic [`DSD_ACC_W-1:0]   dsd_acc_t;
	typedef logic [`DSD_WORD_W-1:0]  dsd_word_t;
	typedef logic [`DSD_SHAMT_W-1:0] dsd_shamt_t;

	typedef enum logic [2:0] {
		DSD_OP_NOP,
		DSD_OP_MUL,
		DSD_OP_MAC,
		DSD_OP_ADD,
		DSD_OP_LOAD,
		DSD_OP_SHACC,
		DSD_OP_SHGP,
		DSD_OP_STORE
	} dsd_op_e;

	typedef enum logic [1:0] {
		DSD_SRC_ACCA,
		DSD_SRC_ACCB,
		DSD_SRC_XBUS
	} dsd_src_e;

	typedef enum logic [1:0] {
		DSD_MUL_SS,
		DSD_MUL_UU,
		DSD_MUL_SU,
		DSD_MUL_US
	} dsd_mul_e;

endpackage

/* rtl/dsd_shift_if.sv */
/*
 * Carrier between the datapath and its barrel shifter.
 * Assumes both ends share one clock; the shifter is purely combinational.
 */
interface dsd_shift_if;
	import dsd_pkg::*;

	dsd_acc_t   operand;
	dsd_word_t  xword;
	logic       from_xbus;
	dsd_shamt_t amount;
	logic       arith;
	dsd_acc_t   result;
	dsd_word_t  result16;

	modport core (output operand, xword, from_xbus, amount, arith,
	              input  result, result16);
	modport unit (input  operand, xword, from_xbus, amount, arith,
	              output result, result16);
endinterface

/* rtl/dsd_barrel.sv */
/*
 * 40-bit bidirectional barrel shifter, single cycle, combinational.
 * Assumes the datapath registers its result; amount is two's complement.
 */
`include "dsd_consts.svh"

module dsd_barrel
(
	dsd_shift_if.unit sh
);
	import dsd_pkg::*;

	dsd_shamt_t mag_full;
	dsd_shamt_t mag;
	logic       right;
	dsd_acc_t   opnd;

	// ======================================================================
	// Direction, magnitude and operand placement
	always_comb
	begin
		right    = ~sh.amount[`DSD_SHAMT_W-1] && (sh.amount != `DSD_SH_ZERO);
		mag_full = sh.amount[`DSD_SHAMT_W-1] ? -sh.amount : sh.amount;
		mag      = (mag_full > `DSD_SH_MAX) ? `DSD_SH_MAX : mag_full;
		if (sh.from_xbus)
		begin
			if (right)
				opnd = {{8{sh.arith & sh.xword[`DSD_WORD_W-1]}}, sh.xword,
				        `DSD_WORD_RST};
			else
				opnd = {{24{1'b0}}, sh.xword};
		end
		else
			opnd = sh.operand;
	end

	// ======================================================================
	// Shift
	always_comb
	begin
		if (right && sh.arith)
			sh.result = $signed(opnd) >>> mag;
		else if (right)
			sh.result = opnd >> mag;
		else
			sh.result = opnd << mag;
		sh.result16 = right ? sh.result[`DSD_XR_MSB:`DSD_XR_LSB]
		                    : sh.result[`DSD_WORD_W-1:`DSD_XL_LSB];
	end
endmodule

/* tb/dsd_mem.sv */
/*
 X/Y data memory model: a small word table read on demand.
 Assumes the bench raises rd_in with an index; idle buses invert.
*/
module dsd_mem
(
	input  logic               rd_in,
	input  logic [2:0]         idx_in,
	output dsd_pkg::dsd_word_t x_out,
	output dsd_pkg::dsd_word_t y_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import dsd_pkg::*;
	dsd_word_t mem [8] = '{16'h0000, 16'h7fff, 16'h8000, 16'h1000,
		16'h8421, 16'h4000, 16'h1234, 16'ha5c3};
	// ========
	// Buses: idle buses carry the inverted word, so stale data cannot pass
	assign x_out = rd_in ? mem[idx_in] : ~mem[idx_in];
	assign y_out = rd_in ? mem[idx_in ^ 3'h1] : ~mem[idx_in ^ 3'h1];
endmodule

/* tb/dsd_datapath_properties.sv */
/*
 Port checker of the datapath: pulses, store path, shifter, prefetch.
 Assumes it is bound into dsd_datapath, one clock domain.
*/
module dsd_datapath_chk
(
	input wire logic               SYS_CLK_IN,
	input wire logic               RSTN_IN,
	input wire dsd_pkg::dsd_op_e   OP_IN,
	input wire logic               ACC_SEL_IN,
	input wire dsd_pkg::dsd_src_e  SHIFT_SRC_IN,
	input wire dsd_pkg::dsd_shamt_t SHIFT_AMT_IN,
	input wire dsd_pkg::dsd_word_t XBUS_IN,
	input wire logic               DATA_WRITE_SATURATION_ENABLE_IN,
	input wire dsd_pkg::dsd_acc_t  ACC_A_OUT,
	input wire dsd_pkg::dsd_acc_t  ACC_B_OUT,
	input wire logic               RESULT_VALID_OUT,
	input wire dsd_pkg::dsd_word_t STORE_DATA_OUT,
	input wire logic               STORE_VALID_OUT,
	input wire logic               STORE_SAT_OUT,
	input wire dsd_pkg::dsd_word_t PREFETCH_X_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	import dsd_pkg::*;
	logic src_neg;
	assign src_neg = ACC_SEL_IN ? ACC_B_OUT[39] : ACC_A_OUT[39];
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	// ========
	// Properties
	res_valid_a: assert property (RESULT_VALID_OUT == ($past(OP_IN) == DSD_OP_MUL
		|| $past(OP_IN) == DSD_OP_SHGP)) else $error("result pulse wrong");
	store_valid_a: assert property (OP_IN == DSD_OP_STORE |=> STORE_VALID_OUT)
		else $error("store pulse missing");
	store_hold_a: assert property (OP_IN != DSD_OP_STORE
		|=> $stable(STORE_DATA_OUT) && !STORE_VALID_OUT) else $error("store word moved");
	acc_keep_a: assert property (OP_IN == DSD_OP_STORE
		|=> $stable(ACC_A_OUT) && $stable(ACC_B_OUT)) else $error("store changed acc");
	sat_off_a: assert property (OP_IN == DSD_OP_STORE && !DATA_WRITE_SATURATION_ENABLE_IN
		|=> !STORE_SAT_OUT) else $error("saturated while off");
	sat_word_a: assert property (STORE_SAT_OUT |-> $past(DATA_WRITE_SATURATION_ENABLE_IN)
		&& STORE_DATA_OUT == ($past(src_neg) ? 16'h8000 : 16'h7fff)) else $error("sat word");
	shift_zero_a: assert property (OP_IN == DSD_OP_SHACC && SHIFT_AMT_IN == 6'h00
		&& SHIFT_SRC_IN == DSD_SRC_ACCB && !ACC_SEL_IN |=> ACC_A_OUT == $past(ACC_B_OUT))
		else $error("zero shift moved data");
	prefetch_x_a: assert property (OP_IN == DSD_OP_MAC
		|=> PREFETCH_X_OUT == $past(XBUS_IN)) else $error("prefetch wrong");
	load_place_a: assert property (OP_IN == DSD_OP_LOAD && !ACC_SEL_IN
		|=> ACC_A_OUT == {{8{$past(XBUS_IN[15])}}, $past(XBUS_IN), 16'h0000})
		else $error("load placement wrong");
endmodule

bind dsd_datapath dsd_datapath_chk dsd_datapath_chk_i
(
	.SYS_CLK_IN, .RSTN_IN, .OP_IN, .ACC_SEL_IN, .SHIFT_SRC_IN, .SHIFT_AMT_IN,
	.XBUS_IN, .DATA_WRITE_SATURATION_ENABLE_IN, .ACC_A_OUT, .ACC_B_OUT,
	.RESULT_VALID_OUT, .STORE_DATA_OUT, .STORE_VALID_OUT, .STORE_SAT_OUT,
	.PREFETCH_X_OUT
);

/* tb/dsd_datapath_tb.sv */
/*
 Self-checking bench of the datapath: shifts, products, MAC, store path.
 Assumes one op per go call, results settled one cycle after it.
*/
module dsd_datapath_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dsd_pkg::*;
	logic       clk = 1'b0, rstn = 1'b0, sel = 1'b0, ar = 1'b0;
	logic       fr = 1'b0, ws = 1'b0, rd = 1'b0, se = 1'b0, rn = 1'b0;
	logic [2:0] ix = 3'h0;
	dsd_op_e    op = DSD_OP_NOP;
	dsd_src_e   src = DSD_SRC_XBUS;
	dsd_shamt_t amt = 6'h00;
	dsd_mul_e   mm = DSD_MUL_SS;
	dsd_word_t  ma = 16'h0000, mb = 16'h0000, xb, yb, r16, sd, px, py;
	dsd_acc_t   acc_a, acc_b, r40;
	logic [1:0] ovf;
	logic       rv, sv, ss;
	int         fails = 0, tests_run = 0;

	dsd_mem dsd_mem_i (.rd_in(rd), .idx_in(ix), .x_out(xb), .y_out(yb));
	dsd_datapath dsd_datapath_i
	(
		.SYS_CLK_IN(clk), .RSTN_IN(rstn), .OP_IN(op), .ACC_SEL_IN(sel),
		.SHIFT_SRC_IN(src), .SHIFT_AMT_IN(amt), .SHIFT_ARITH_IN(ar),
		.XBUS_IN(xb), .YBUS_IN(yb), .MUL_OPA_IN(ma), .MUL_OPB_IN(mb),
		.MUL_MODE_IN(mm), .MUL_FRAC_IN(fr), .ACC_SAT_EN_IN(se),
		.ROUND_EN_IN(rn), .DATA_WRITE_SATURATION_ENABLE_IN(ws),
		.ACC_A_OUT(acc_a), .ACC_B_OUT(acc_b), .ACC_OVF_OUT(ovf),
		.RESULT40_OUT(r40), .RESULT16_OUT(r16), .RESULT_VALID_OUT(rv),
		.STORE_DATA_OUT(sd), .STORE_VALID_OUT(sv), .STORE_SAT_OUT(ss),
		.PREFETCH_X_OUT(px), .PREFETCH_Y_OUT(py)
	);
	initial
		forever #5 clk = ~clk;

	// ========
	// Compare and drive helpers
	task automatic miss(logic [39:0] g, logic [39:0] e);
		fails++;
		$display("unexpected at %0t: got %h want %h", $time, g, e);
	endtask
	task automatic chk40(dsd_acc_t g, dsd_acc_t e);
		tests_run++;
		if (g !== e)
			miss(g, e);
	endtask
	task automatic chk16(dsd_word_t g, dsd_word_t e);
		tests_run++;
		if (g !== e)
			miss(g, e);
	endtask
	task automatic chk1(logic g, logic e);
		tests_run++;
		if (g !== e)
			miss(g, e);
	endtask
	// Called at a rising edge; returns just after the edge that takes the op
	task automatic go(dsd_op_e o, logic s, logic [2:0] i);
		op <= o;
		sel <= s;
		ix <= i;
		rd <= 1'b1;
		@(posedge clk);
		op <= DSD_OP_NOP;
		rd <= 1'b0;
		#1;
	endtask
	function automatic dsd_acc_t expsh(dsd_word_t x, int n, logic a);
		dsd_acc_t v;
		if (n <= 0)
			return {24'h000000, x} << -n;
		v = {{8{a & x[15]}}, x, 16'h0000};
		if (a)
			v = $signed(v) >>> n;
		else
			v = v >> n;
		return v;
	endfunction

	// ========
	// Scenarios
	task automatic shift_test();
		dsd_shamt_t am [5] = '{6'h10, 6'h01, 6'h30, 6'h3d, 6'h00};
		dsd_acc_t   e;
		int         n;
		for (int k = 0; k < 10; k++)
		begin
			n = $signed(am[k / 2]);
			e = expsh(dsd_mem_i.mem[4], n, k[0]);
			@(posedge clk);
			src <= DSD_SRC_XBUS;
			amt <= am[k / 2];
			ar <= k[0];
			go(DSD_OP_SHGP, 1'b0, 3'h4);
			chk40(r40, e);
			chk16(r16, n > 0 ? e[31:16] : e[15:0]);
			chk1(rv, 1'b1);
		end
		@(posedge clk);
		go(DSD_OP_LOAD, 1'b0, 3'h4);
		e = expsh(dsd_mem_i.mem[4], 4, 1'b1);
		@(posedge clk);
		src <= DSD_SRC_ACCA;
		amt <= 6'h04;
		ar <= 1'b1;
		go(DSD_OP_SHACC, 1'b1, 3'h0);
		chk40(acc_b, e);
		@(posedge clk);
		src <= DSD_SRC_ACCB;
		amt <= 6'h00;
		go(DSD_OP_SHACC, 1'b0, 3'h0);
		chk40(acc_a, e);
	endtask
	task automatic mul_test();
		dsd_word_t av [5] = '{16'h8000, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
		dsd_word_t bv [5] = '{16'h8000, 16'h0002, 16'hffff, 16'hffff, 16'hffff};
		dsd_mul_e  mv [5] = '{DSD_MUL_SS, DSD_MUL_SS, DSD_MUL_UU, DSD_MUL_SU, DSD_MUL_US};
		logic signed [33:0] p;
		logic      sa, sb;
		for (int k = 0; k < 5; k++)
		begin
			sa = (mv[k] == DSD_MUL_SS || mv[k] == DSD_MUL_SU) & av[k][15];
			sb = (mv[k] == DSD_MUL_SS || mv[k] == DSD_MUL_US) & bv[k][15];
			p = $signed({sa, av[k]}) * $signed({sb, bv[k]});
			@(posedge clk);
			ma <= av[k];
			mb <= bv[k];
			mm <= mv[k];
			fr <= (k == 0);
			go(DSD_OP_MUL, 1'b0, 3'h0);
			chk40(r40, k == 0 ? {{5{p[33]}}, p, 1'b0} : {{6{p[33]}}, p});
			if (k > 0)
				chk16(r16, p[15:0]);
		end
	endtask
	task automatic mac_test();
		@(posedge clk);
		go(DSD_OP_LOAD, 1'b0, 3'h0);
		for (int k = 1; k < 3; k++)
		begin
			@(posedge clk);
			ma <= 16'h4000;
			mb <= 16'h4000;
			mm <= DSD_MUL_SS;
			fr <= 1'b1;
			go(DSD_OP_MAC, 1'b0, 3'h6);
			chk40(acc_a, 40'h00_2000_0000 * k);
			chk16(px, dsd_mem_i.mem[6]);
			chk16(py, dsd_mem_i.mem[7]);
			chk1(ovf[0], 1'b0);
		end
	endtask
	task automatic sat_test();
		dsd_word_t w, e;
		dsd_acc_t  s;
		logic      o;
		for (int k = 0; k < 6; k++)
		begin
			w = dsd_mem_i.mem[k / 2 + 1];
			s = {{7{w[15]}}, w, 17'h00000};
			o = k[0] && s[39:31] != {9{s[39]}};
			e = o ? (s[39] ? 16'h8000 : 16'h7fff) : s[31:16];
			@(posedge clk);
			go(DSD_OP_LOAD, 1'b0, 3'(k / 2 + 1));
			@(posedge clk);
			go(DSD_OP_LOAD, 1'b1, 3'(k / 2 + 1));
			@(posedge clk);
			ws <= k[0];
			go(DSD_OP_ADD, 1'b0, 3'h0);
			chk40(acc_a, s);
			@(posedge clk);
			go(DSD_OP_STORE, 1'b0, 3'h0);
			chk16(sd, e);
			chk1(ss, o);
			chk1(sv, 1'b1);
			chk40(acc_a, s);
		end
	endtask
	task automatic acc_sat_test();
		@(posedge clk);
		go(DSD_OP_LOAD, 1'b0, 3'h1);
		@(posedge clk);
		src <= DSD_SRC_ACCA;
		amt <= 6'h38;
		go(DSD_OP_SHACC, 1'b1, 3'h0);
		chk40(acc_b, 40'h7f_ff00_0000);
		@(posedge clk);
		go(DSD_OP_SHACC, 1'b0, 3'h0);
		@(posedge clk);
		se <= 1'b1;
		go(DSD_OP_ADD, 1'b0, 3'h0);
		chk40(acc_a, 40'h7f_ffff_ffff);
		chk1(ovf[0], 1'b1);
		chk1(ovf[1], 1'b0);
		@(posedge clk);
		se <= 1'b0;
		go(DSD_OP_ADD, 1'b1, 3'h0);
		chk40(acc_b, 40'hff_feff_ffff);
		chk1(ovf[1], 1'b1);
		@(posedge clk);
		se <= 1'b1;
		ma <= 16'h4000;
		mb <= 16'h4000;
		mm <= DSD_MUL_SS;
		fr <= 1'b1;
		go(DSD_OP_MAC, 1'b0, 3'h0);
		chk40(acc_a, 40'h7f_ffff_ffff);
		chk1(ovf[0], 1'b1);
	endtask
	task automatic round_test();
		@(posedge clk);
		se <= 1'b0;
		src <= DSD_SRC_XBUS;
		amt <= 6'h10;
		ar <= 1'b0;
		go(DSD_OP_SHACC, 1'b0, 3'h2);
		chk40(acc_a, 40'h00_0000_8000);
		@(posedge clk);
		go(DSD_OP_LOAD, 1'b1, 3'h1);
		@(posedge clk);
		go(DSD_OP_ADD, 1'b0, 3'h0);
		@(posedge clk);
		rn <= 1'b1;
		ws <= 1'b1;
		go(DSD_OP_STORE, 1'b0, 3'h0);
		chk16(sd, 16'h7fff);
		chk1(ss, 1'b1);
		@(posedge clk);
		ws <= 1'b0;
		go(DSD_OP_STORE, 1'b0, 3'h0);
		chk16(sd, 16'h8000);
		chk1(ss, 1'b0);
		@(posedge clk);
		rn <= 1'b0;
		ws <= 1'b1;
		go(DSD_OP_STORE, 1'b0, 3'h0);
		chk16(sd, 16'h7fff);
		chk1(ss, 1'b0);
		chk40(acc_a, 40'h00_7fff_8000);
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		chk40(acc_a, 40'h0);
		chk1(rv, 1'b0);
		rstn <= 1'b1;
		shift_test();
		mul_test();
		mac_test();
		sat_test();
		acc_sat_test();
		round_test();
		finish_test();
	end
	initial
	begin
		#50000;
		fails++;
		finish_test();
	end
endmodule
